// [shared/serdes_pkg.sv]
// serdes_pkg: shared constants, tables and carriers of the dual-byte 8b/10b datapath.
// assumes one 50 MHz word clock; a serial word is 20 bits with bit 0 sent first.
package serdes_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int BITS_PER_WORD = 20;
	localparam int TX_LAT_MIN_BITS = 34;
	localparam int TX_LAT_MAX_BITS = 38;
	localparam int RX_LAT_MIN_BITS = 76;
	localparam int RX_LAT_MAX_BITS = 107;
	// least latency rounded up to whole word cycles
	localparam int TX_LAT_CYCLES = (TX_LAT_MIN_BITS + BITS_PER_WORD - 1) / BITS_PER_WORD;
	localparam int RX_LAT_CYCLES = (RX_LAT_MIN_BITS + BITS_PER_WORD - 1) / BITS_PER_WORD;
	localparam int PASS_SYNC_WORDS = 2;

	////////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on a 32-bit bus
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam int CTRL_PATTERN_BIT = 0;
	localparam int STAT_LOST_BIT = 0;
	localparam int STAT_PASS_BIT = 1;
	localparam int STAT_ALIGNED_BIT = 2;
	localparam int STAT_DECERR_BIT = 3;
	localparam logic CTRL_PATTERN_RST = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// line code values
	localparam logic [6:0] COMMA_BITS = 7'h7C;
	localparam logic [7:0] ERR_BYTE = 8'h00;
	localparam logic [7:0] LOST_BYTE = 8'hFF;
	localparam logic [4:0] K28_X = 5'h1C;
	localparam logic [5:0] K28_6B = 6'h0F;
	localparam logic [3:0] ALT7_4B = 4'h7;
	localparam logic [6:0] PRBS_SEED = 7'h7F;
	// 5b/6b codes at negative disparity, bit a in the msb
	localparam logic [5:0] ENC6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	// 3b/4b codes at negative disparity, bit f in the msb
	localparam logic [3:0] ENC4 [8] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

	////////////////////////////////////////////////////////////////////////////////
	// parallel word with its per-byte k flags
	typedef struct packed {
		logic high_byte_kflag;
		logic low_byte_kflag;
		logic [15:0] data;
	} word_t;

endpackage

// [verilog/serdes_datapath.sv]
// serdes_datapath: transmit encoder and pattern source, receive aligner,
// decoder, pattern checker and a small register slave.
// assumes an external serializer/deserializer moving 20-bit words, bit 0 first,
// and that every input is synchronous to clk_i.
//
// Summary of operation
// - transmit word and flags sampled at rising edge
// - transmit latency fixed by register pipeline
// - each byte has own balanced 8b/10b encoder
// - each k flag picks K or D independently
// - pattern mode replaces transmit input with prbs
// - 20-bit word leaves low bit first
// - receive word and flags driven from flops
// - receive latency fixed by register pipeline
// - earliest received bit lands in bit 0
// - align only on positive comma 0011111
// - two decoders latched together into one word
// - receive k flags report K versus D
// - only twelve listed K characters accepted
// - bad byte alone shows K0.0
// - lost signal shows K31.7 on both bytes
// - word valid held low during reset
// - pattern mode: low k flag shows pass
// - lost signal drives every rx_out_o bit high
module serdes_datapath
	import serdes_pkg::*;
#(
	parameter int SYNC_WORDS = PASS_SYNC_WORDS
)(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire word_t tx_in_i,
	output logic [19:0] tx_serial_word_o,
	input wire logic [19:0] rx_serial_word_i,
	input wire logic signal_lost_i,
	output word_t rx_out_o,
	output logic rx_word_valid_o
);

	if (SYNC_WORDS < 1 || SYNC_WORDS > 15)
	begin : g_bad_sync
		$error("SYNC_WORDS must lie in 1..15");
	end

	////////////////////////////////////////////////////////////////////////////////
	// line code functions

	// returns {disparity out, code}; code bit 0 goes on the line first
	function automatic logic [10:0] encode_char(input logic [7:0] b, input logic k,
		input logic rd);
		logic [5:0] s6;
		logic [3:0] s4;
		logic [9:0] c;
		logic rd6;
		logic alt;
		s6 = (k && b[4:0] == K28_X) ? K28_6B : ENC6[b[4:0]];
		if (rd && ($countones(s6) != 3 || b[4:0] == 5'h07))
			s6 = ~s6;
		rd6 = ($countones(s6) == 3) ? rd : ($countones(s6) > 3);
		alt = (b[7:5] == 3'h7) && (k || (!rd6 && (b[4:0] == 5'h11 || b[4:0] == 5'h12
			|| b[4:0] == 5'h14)) || (rd6 && (b[4:0] == 5'h0B || b[4:0] == 5'h0D
			|| b[4:0] == 5'h0E)));
		s4 = alt ? ALT7_4B : ENC4[b[7:5]];
		if (rd6 && ($countones(s4) != 2 || b[7:5] == 3'h3))
			s4 = ~s4;
		else if (k && !rd6 && $countones(s4) == 2 && b[7:5] != 3'h3)
			s4 = ~s4;
		c = {<<{s6, s4}};
		return {(($countones(s4) == 2) ? rd6 : ($countones(s4) > 2)), c};
	endfunction

	function automatic logic k_listed(input logic [7:0] b);
		return b[4:0] == K28_X || (b[7:5] == 3'h7 && (b[4:0] == 5'h17
			|| b[4:0] == 5'h1B || b[4:0] == 5'h1D || b[4:0] == 5'h1E));
	endfunction

	// returns {error, k, byte}; an error reads as K0.0
	function automatic logic [9:0] decode_char(input logic [9:0] code, input logic rd);
		logic [9:0] r;
		logic [10:0] e;
		r = {1'b1, 1'b1, ERR_BYTE};
		for (int i = 0; i < 512; i++)
		begin
			e = encode_char(i[7:0], i[8], rd);
			if (e[9:0] == code && (!i[8] || k_listed(i[7:0])))
				r = {1'b0, i[8], i[7:0]};
		end
		return r;
	endfunction

	function automatic logic next_rd(input logic [9:0] code, input logic rd);
		return ($countones(code) == 5) ? rd : ($countones(code) > 5);
	endfunction

	// runs x7+x6+1 over 20 bits; returns {mismatch, bits}
	function automatic logic [20:0] prbs_run(input logic [6:0] h, input logic [19:0] in,
		input logic gen);
		logic [26:0] e;
		logic bad;
		e = {20'h00000, h};
		bad = 1'b0;
		for (int i = 0; i < 20; i++)
		begin
			e[i + 7] = gen ? (e[i + 1] ^ e[i]) : in[i];
			bad = bad | (e[i + 7] != (e[i + 1] ^ e[i]));
		end
		return {bad, e[26:7]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// register slave

	logic ctrl_pattern_q;
	logic dec_err_q;
	logic synced_q;
	logic failed_q;
	logic aligned_q;
	logic [31:0] status_w;
	logic bus_req;
	logic bus_done;
	logic dec_err_ev;

	assign bus_req = avs_read_i | avs_write_i;
	assign bus_done = bus_req & ~avs_waitrequest_o;
	assign status_w = {28'h0000000, dec_err_q, aligned_q, synced_q & ~failed_q,
		signal_lost_i};

	// one wait state per access keeps read data registered
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			avs_waitrequest_o <= 1'b1;
		else
			avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
	end

	// read data captured in the wait cycle; unmapped reads give zero
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= (avs_address_i == CTRL_OFS) ? {31'h00000000, ctrl_pattern_q}
				: (avs_address_i == STATUS_OFS) ? status_w : 32'h00000000;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ctrl_pattern_q <= CTRL_PATTERN_RST;
		else if (bus_done && avs_write_i && avs_address_i == CTRL_OFS && avs_byteenable_i[0])
			ctrl_pattern_q <= avs_writedata_i[CTRL_PATTERN_BIT];
	end

	// sticky decode error, write one to clear; a new error wins over the clear
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			dec_err_q <= 1'b0;
		else if (dec_err_ev)
			dec_err_q <= 1'b1;
		else if (bus_done && avs_write_i && avs_address_i == STATUS_OFS
			&& avs_byteenable_i[0] && avs_writedata_i[STAT_DECERR_BIT])
			dec_err_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmit path

	word_t tx_in_q;
	logic tx_rd_q;
	logic [6:0] tx_prbs_q;
	logic [10:0] enc_lo;
	logic [10:0] enc_hi;
	logic [20:0] prbs_tx;

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			tx_in_q <= '0;
		else
			tx_in_q <= tx_in_i;
	end

	assign enc_lo = encode_char(tx_in_q.data[7:0], tx_in_q.low_byte_kflag, tx_rd_q);
	assign enc_hi = encode_char(tx_in_q.data[15:8], tx_in_q.high_byte_kflag, enc_lo[10]);
	assign prbs_tx = prbs_run(tx_prbs_q, 20'h00000, 1'b1);

	// disparity starts negative and holds across pattern mode
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			tx_rd_q <= 1'b0;
		else if (!ctrl_pattern_q)
			tx_rd_q <= enc_hi[10];
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			tx_prbs_q <= PRBS_SEED;
		else if (ctrl_pattern_q)
			tx_prbs_q <= prbs_tx[19:13];
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			tx_serial_word_o <= 20'h00000;
		else if (ctrl_pattern_q)
			tx_serial_word_o <= prbs_tx[19:0];
		else
			tx_serial_word_o <= {enc_hi[9:0], enc_lo[9:0]};
	end

	////////////////////////////////////////////////////////////////////////////////
	// receive alignment

	logic [19:0] rx_prev_q;
	logic [39:0] window;
	logic [39:0] shifted;
	logic comma_hit;
	logic [4:0] comma_pos;
	logic [4:0] align_off_q;
	logic [19:0] aligned_word_q;

	assign window = {rx_serial_word_i, rx_prev_q};
	assign shifted = window >> align_off_q;

	// positive comma only; earliest match wins
	always_comb
	begin
		comma_hit = 1'b0;
		comma_pos = 5'h00;
		for (int o = 0; o < 20; o++)
		begin
			if (!comma_hit && window[o +: 7] == COMMA_BITS)
			begin
				comma_hit = 1'b1;
				comma_pos = o[4:0];
			end
		end
	end

	// the comma character becomes the low byte of the aligned word
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			align_off_q <= 5'h00;
			aligned_q <= 1'b0;
		end
		else if (signal_lost_i)
			aligned_q <= 1'b0;
		else if (comma_hit)
		begin
			align_off_q <= comma_pos;
			aligned_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			rx_prev_q <= 20'h00000;
			aligned_word_q <= 20'h00000;
		end
		else
		begin
			rx_prev_q <= rx_serial_word_i;
			aligned_word_q <= shifted[19:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receive decode and pattern check

	logic rx_rd_q;
	logic rd_mid;
	logic [9:0] dec_lo;
	logic [9:0] dec_hi;
	logic [20:0] prbs_rx;
	logic [6:0] chk_hist_q;
	logic [3:0] sync_cnt_q;

	assign dec_lo = decode_char(aligned_word_q[9:0], rx_rd_q);
	assign rd_mid = next_rd(aligned_word_q[9:0], rx_rd_q);
	assign dec_hi = decode_char(aligned_word_q[19:10], rd_mid);
	assign dec_err_ev = aligned_q & ~signal_lost_i & (dec_lo[9] | dec_hi[9]);
	assign prbs_rx = prbs_run(chk_hist_q, rx_serial_word_i, 1'b0);

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rx_rd_q <= 1'b0;
		else
			rx_rd_q <= next_rd(aligned_word_q[19:10], rd_mid);
	end

	// sync first, then errors are sticky until the mode is left
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			chk_hist_q <= 7'h00;
			sync_cnt_q <= 4'h0;
			synced_q <= 1'b0;
			failed_q <= 1'b0;
		end
		else
		begin
			chk_hist_q <= rx_serial_word_i[19:13];
			if (!ctrl_pattern_q)
			begin
				sync_cnt_q <= 4'h0;
				synced_q <= 1'b0;
				failed_q <= 1'b0;
			end
			else if (synced_q)
				failed_q <= failed_q | prbs_rx[20];
			else if (prbs_rx[20])
				sync_cnt_q <= 4'h0;
			else if (sync_cnt_q == 4'(SYNC_WORDS - 1))
				synced_q <= 1'b1;
			else
				sync_cnt_q <= sync_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rx_out_o <= '0;
		else if (signal_lost_i)
			rx_out_o <= {1'b1, 1'b1, LOST_BYTE, LOST_BYTE};
		else
			rx_out_o <= {dec_hi[8], ctrl_pattern_q ? (synced_q & ~failed_q) : dec_lo[8],
				dec_hi[7:0], dec_lo[7:0]};
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rx_word_valid_o <= 1'b0;
		else
			rx_word_valid_o <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// the first edge after release still shows the all-zero reset word
	chk_tx_balance: assert property (!ctrl_pattern_q && $past(!ctrl_pattern_q)
		&& !$past(sys_rst_i) |->
		$countones(tx_serial_word_o[9:0]) inside {4, 5, 6}
		&& $countones(tx_serial_word_o[19:10]) inside {4, 5, 6})
		else $error("transmit character not balanced");

	chk_tx_pattern: assert property (ctrl_pattern_q ##1 ctrl_pattern_q |->
		tx_serial_word_o == $past(prbs_tx[19:0]))
		else $error("pattern word not sent");

	chk_rx_lost: assert property ($past(signal_lost_i) |->
		rx_out_o == {1'b1, 1'b1, LOST_BYTE, LOST_BYTE})
		else $error("lost signal not shown");

	chk_rx_err_code: assert property (dec_lo[9] && !signal_lost_i && !ctrl_pattern_q |=>
		rx_out_o.data[7:0] == ERR_BYTE && rx_out_o.low_byte_kflag)
		else $error("bad low byte not K0.0");

	chk_rx_pass_flag: assert property (ctrl_pattern_q && !signal_lost_i |=>
		rx_out_o.low_byte_kflag == $past(synced_q && !failed_q))
		else $error("pass flag wrong");

	chk_align_comma: assert property (comma_hit && !signal_lost_i |=>
		align_off_q == $past(comma_pos) && aligned_q)
		else $error("alignment not taken");

	chk_prbs_fail: assert property ($rose(failed_q) |->
		$past(prbs_rx[20]) && $past(synced_q))
		else $error("pattern failure without error");

	chk_k_listed: assert property (!dec_hi[9] && dec_hi[8] && !signal_lost_i |=>
		k_listed(rx_out_o.data[15:8]) && rx_out_o.high_byte_kflag)
		else $error("unlisted K accepted");

	chk_bus_wait: assert property (bus_req && avs_waitrequest_o |=> !avs_waitrequest_o
		##1 avs_waitrequest_o)
		else $error("bus answer not one wait state");

endmodule

// [dv/link_partner.sv]
// link_partner: loops transmit words back as receive words over a model link.
// assumes one 20-bit word per clock, bit 0 earliest, in both directions.
module link_partner (
	input wire logic clk_i,
	input wire logic [19:0] tx_word_i,
	input wire logic [4:0] slip_i,
	input wire logic fault_i,
	input wire logic lost_i,
	output logic [19:0] rx_word_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [19:0] prev_q;
	logic [19:0] cur;
	logic [39:0] line;

	////////////////////////////////////////////////////////////////////////////////
	// an all-zero high char is never a legal code, so a fault hits one byte only
	assign cur = fault_i ? {10'h000, tx_word_i[9:0]} : tx_word_i;
	assign line = {cur, prev_q};

	// the slip moves the word boundary; a dead line toggles rather than holding
	always_ff @(posedge clk_i)
	begin
		prev_q <= cur;
		rx_word_o <= lost_i ? ~rx_word_o : line[20 - int'(slip_i) +: 20];
	end
endmodule

// [dv/tb.sv]
// tb: loopback bench for the dual-byte line-coding datapath.
// assumes link_partner closes the serial loop and the register bus is idle at reset.
module tb
	import serdes_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] KL [12] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC,
		8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE};
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] got;
	logic wait_o;
	word_t tx_in = '0;
	logic [19:0] tx_ser;
	logic [19:0] rx_ser;
	logic [19:0] t0;
	logic lost = 1'b0;
	word_t rx_out;
	logic rx_vld;
	logic [4:0] slip = 5'h0;
	logic fault = 1'b0;
	int mismatches = 0;
	int samples_checked = 0;
	int lat;
	int lat0;
	word_t seq [20];

	////////////////////////////////////////////////////////////////////////////////
	// free-running word clock
	initial
	begin
		forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
	end

	serdes_datapath #(.SYNC_WORDS(2)) dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
		.tx_in_i(tx_in), .tx_serial_word_o(tx_ser), .rx_serial_word_i(rx_ser),
		.signal_lost_i(lost), .rx_out_o(rx_out), .rx_word_valid_o(rx_vld));

	link_partner link (.clk_i(clk_i), .tx_word_i(tx_ser), .slip_i(slip),
		.fault_i(fault), .lost_i(lost), .rx_word_o(rx_ser));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask

	// one avalon access; the request stands until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		adr <= a;
		wr <= w;
		rd <= ~w;
		wdat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wait_o !== 1'b0 && n < 40);
		got = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 40)
			check("bus wait", 32'h0, 32'h1);
	endtask

	// bounded wait for a receive word, then compare it
	task automatic wait_rx(input string what, input word_t w);
		int n;
		n = 0;
		while (rx_out !== w && n < 12)
		begin
			@(negedge clk_i);
			n++;
		end
		check(what, 32'(w), 32'(rx_out));
	endtask

	// sends seq and expects it back in order; lat counts cycles to seq[4]
	task automatic run();
		@(posedge clk_i);
		fork
			for (int i = 0; i < 20; i++)
			begin
				tx_in <= seq[i];
				@(posedge clk_i);
			end
			begin
				lat = 0;
				while (rx_out !== seq[4] && lat < 40)
				begin
					@(negedge clk_i);
					lat++;
				end
				for (int k = 5; k < 20; k++)
				begin
					@(negedge clk_i);
					check("rx word", 32'(seq[k]), 32'(rx_out));
					if (k == 5)
						t0 = 20'(rx_out);
				end
			end
		join
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		for (int i = 0; i < 4; i++)
			seq[i] = '{1'b0, 1'b1, 16'h00BC};
		for (int i = 0; i < 12; i++)
		begin
			seq[i + 4].data = {(i % 2 == 1) ? KL[8 + (i / 2) % 4] : 8'h00, KL[i]};
			seq[i + 4].low_byte_kflag = 1'b1;
			seq[i + 4].high_byte_kflag = (i % 2 == 1);
		end
		for (int j = 0; j < 4; j++)
			seq[j + 16] = '{1'b0, 1'b0, 16'hA5C3 ^ 16'(j)};
		repeat (7) @(posedge clk_i);
		@(negedge clk_i);
		check("rst valid", 32'h0, 32'(rx_vld));
		check("rst wait", 32'h1, 32'(wait_o));
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		tx_in <= '{1'b0, 1'b1, 16'h00BC};
		repeat (2) @(negedge clk_i);
		check("valid", 32'h1, 32'(rx_vld));
		check("tx d0.0", 32'h2E4B9, 32'(tx_ser));
		@(negedge clk_i);
		check("tx k28.5", 32'hD197C, 32'(tx_ser));
		bus(1'b0, CTRL_OFS, 32'h0);
		check("ctrl rst", 32'(CTRL_PATTERN_RST), got);
		bus(1'b1, 4'h8, 32'hFFFFFFFF);
		bus(1'b0, 4'h8, 32'h0);
		check("unmapped", 32'h0, got);
		bus(1'b0, CTRL_OFS, 32'h0);
		check("ctrl kept", 32'h0, got);
		// same stream at two bit slips; latency must repeat at the same slip
		slip <= 5'd0;
		run();
		slip <= 5'd13;
		run();
		lat0 = lat;
		run();
		check("rx latency", 32'(lat0), 32'(lat));
		check("rx k flags", 32'(seq[5].high_byte_kflag), 32'(t0[17]));
		// one corrupted high char
		@(posedge clk_i);
		tx_in <= '{1'b0, 1'b1, 16'h5ABC};
		repeat (8) @(posedge clk_i);
		fault <= 1'b1;
		@(posedge clk_i);
		fault <= 1'b0;
		wait_rx("bad byte", '{1'b1, 1'b1, 16'h00BC});
		bus(1'b0, STATUS_OFS, 32'h0);
		check("err sticky", 32'h1, 32'(got[STAT_DECERR_BIT]));
		bus(1'b1, STATUS_OFS, 32'h1 << STAT_DECERR_BIT);
		bus(1'b0, STATUS_OFS, 32'h0);
		check("err clear", 32'h0, 32'(got[STAT_DECERR_BIT]));
		// loss of signal
		@(posedge clk_i);
		lost <= 1'b1;
		repeat (2) @(negedge clk_i);
		check("lost word", 32'h3FFFF, 32'(rx_out));
		bus(1'b0, STATUS_OFS, 32'h0);
		check("lost stat", 32'h1, 32'(got[STAT_LOST_BIT]));
		check("lost align", 32'h0, 32'(got[STAT_ALIGNED_BIT]));
		@(posedge clk_i);
		lost <= 1'b0;
		wait_rx("relock", '{1'b0, 1'b1, 16'h5ABC});
		// pattern mode overrides the parallel input
		bus(1'b1, CTRL_OFS, 32'h1);
		repeat (4) @(negedge clk_i);
		t0 = tx_ser;
		@(negedge clk_i);
		check("prbs runs", 32'h1, 32'(tx_ser !== t0));
		repeat (20) @(negedge clk_i);
		check("pass flag", 32'h1, 32'(rx_out.low_byte_kflag));
		bus(1'b0, STATUS_OFS, 32'h0);
		check("pass stat", 32'h1, 32'(got[STAT_PASS_BIT]));
		@(posedge clk_i);
		fault <= 1'b1;
		@(posedge clk_i);
		fault <= 1'b0;
		repeat (6) @(negedge clk_i);
		check("fail flag", 32'h0, 32'(rx_out.low_byte_kflag));
		bus(1'b1, CTRL_OFS, 32'h0);
		bus(1'b0, CTRL_OFS, 32'h0);
		check("ctrl off", 32'h0, got);
		final_report();
	end

	// watchdog: the whole sequence needs well under a thousand cycles
	initial
	begin
		#(CLK_PERIOD_NS * 5000);
		mismatches++;
		final_report();
	end
endmodule
